// ---- smp_master.sv ----
// Master-only serial peripheral port with register port and serial pins.
// How it works
// - Separate transmit and receive holding registers allow back-to-back bytes.
// - Idle clock level follows polarity; sample on falling or rising edge.
// - Outgoing bit changes on leading edge, stable at sampling edge.
// - Fixed phase: first bit is driven on the first clock edge.
// - Bit order select: 0 MSB first, 1 LSB first, both directions.
// - Serial clock period equals the sum of selected divisors.
// - Divider bits 7..2 weigh 128..4; reset value 04h.
// - Transmit and receive enables at control bits 6 and 5.
// - Transmit enable clear stops everything, clock held at idle level.
// - Control bit 4 enables the whole port.
// - Auto select drives select low around each byte.
// - Auto select clear: finish current byte, then select stays high.
// - Control register 1 bits 3..0 enable the four interrupt sources.
// - Transfer end flag, status bit 3, cleared by status read.
// - Overrun flag, status bit 2, cleared by status read.
// - Transmit empty clears on holding write, sets on shift load.
// - Receive full sets on byte arrival, clears on holding read.
// - Busy, status bit 4, is high while a byte is in progress.
// - Status resets to 02h and is read-only.
// - Transmit holding write-only at D4h, receive holding read-only at D5h.
// - Reset clears both control registers to 00h.
// - Each byte shifts 8 bits out while shifting 8 bits in.
// - Exactly one clock period per bit, no pulses between bytes.
`timescale 1ns/10ps
module smp_master (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   output logic irq,
   output logic serial_clock_out,
   output logic serial_data_out,
   output logic slave_select_out,
   input wire logic serial_data_in
);

   localparam int DIV_LSB = smp_pkg::DIV_LSB;

   // Half of the serial clock period in peripheral clocks.
   function automatic logic [7:0] fn_half(input logic [7:0] div);
      fn_half = {1'b0, div[7:DIV_LSB], 1'b0};
   endfunction : fn_half

   // Bit that leaves the shift register next.
   function automatic logic fn_outbit(input logic [7:0] sh, input logic lsb);
      fn_outbit = lsb ? sh[0] : sh[7];
   endfunction : fn_outbit

   // One shift step in the chosen bit order, taking a new bit in at the far end.
   function automatic logic [7:0] fn_shift(input logic [7:0] sh, input logic lsb,
                                           input logic din);
      fn_shift = lsb ? {din, sh[7:1]} : {sh[6:0], din};
   endfunction : fn_shift

   logic [7:0] serial_clock_divider;
   logic [7:0] serial_port_control;
   logic [7:0] serial_irq_enable;
   logic [7:0] transmit_holding;
   logic [7:0] receive_holding;
   logic tx_empty_flag;
   logic rx_full_flag;
   logic xfer_end_flag;
   logic overrun_flag;
   smp_pkg::smp_state_t st;
   logic [7:0] cnt;
   logic [3:0] edge_cnt;
   logic [7:0] shreg;
   logic [7:0] rxreg;
   logic [7:0] next_rxreg;
   logic [1:0] samp_dly;
   logic [1:0] done_dly;
   logic rx_s1;
   logic rx_s2;
   logic [7:0] buf_mem [0:1];
   logic buf_wptr;
   logic buf_rptr;
   logic [1:0] buf_count;

   // Decoded control fields.
   logic tx_enable;
   logic rx_enable;
   logic port_enable;
   logic auto_sel;
   logic lsb_first_sel;
   logic clock_idle_high;
   assign tx_enable = serial_port_control[smp_pkg::B_TX_ENABLE];
   assign rx_enable = serial_port_control[smp_pkg::B_RX_ENABLE];
   assign port_enable = serial_port_control[smp_pkg::B_PORT_ENABLE];
   assign auto_sel = serial_port_control[smp_pkg::B_AUTO_SEL];
   assign lsb_first_sel = serial_port_control[smp_pkg::B_LSB_FIRST];
   assign clock_idle_high = serial_port_control[smp_pkg::B_IDLE_HIGH];

   // Register port strobes.
   logic wr_tx;
   logic rd_rx;
   logic rd_stat;
   assign wr_tx = sfr_wr && (sfr_addr == smp_pkg::ADDR_TXHOLD);
   assign rd_rx = sfr_rd && (sfr_addr == smp_pkg::ADDR_RXHOLD);
   assign rd_stat = sfr_rd && (sfr_addr == smp_pkg::ADDR_STATUS);

   // Engine timing and events.
   logic run_ok;
   logic tick;
   logic busy;
   logic go;
   logic trail_edge;
   logic byte_done;
   logic [7:0] next_shreg;
   logic buf_in_valid;
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_ready;
   assign run_ok = port_enable && tx_enable;
   assign tick = (cnt == fn_half(serial_clock_divider) - 8'h01);
   assign busy = (st != smp_pkg::SMP_IDLE);
   // Start needs a queued byte and room for the answer; a full buffer stalls.
   assign go = run_ok && !tx_empty_flag && buf_in_ready;
   assign trail_edge = run_ok && (st == smp_pkg::SMP_SHIFT) && tick && edge_cnt[0];
   assign byte_done = trail_edge && (edge_cnt == smp_pkg::LAST_EDGE);
   assign next_shreg = fn_shift(shreg, lsb_first_sel, 1'b0);
   assign next_rxreg = fn_shift(rxreg, lsb_first_sel, rx_s2);
   assign buf_in_valid = done_dly[1] && rx_enable;
   assign buf_in_ready = (buf_count != smp_pkg::BUF_DEPTH);
   assign buf_out_valid = (buf_count != 2'h0);
   assign buf_out_ready = !rx_full_flag || rd_rx;

   // Two-flop synchroniser for the serial data input pin.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rx_s1 <= 1'b0;
         rx_s2 <= 1'b0;
      end else begin
         rx_s1 <= serial_data_in;
         rx_s2 <= rx_s1;
      end
   end

   // Delayed sampling
   // The synchroniser lags two clocks, so the pin level at each sampling edge lands later.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         samp_dly <= 2'b00;
         done_dly <= 2'b00;
         rxreg <= 8'h00;
      end else begin
         samp_dly <= {samp_dly[0], trail_edge};
         done_dly <= {done_dly[0], byte_done};
         if (samp_dly[1]) begin
            rxreg <= next_rxreg;
         end
      end
   end

   // Software-written registers.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         serial_clock_divider <= smp_pkg::RST_CLKDIV;
         serial_port_control <= smp_pkg::RST_CTRL;
         serial_irq_enable <= smp_pkg::RST_IRQEN;
      end else if (sfr_wr) begin
         if (sfr_addr == smp_pkg::ADDR_CLKDIV) begin
            serial_clock_divider <= {sfr_wdata[7:DIV_LSB], 2'b00};
         end
         if (sfr_addr == smp_pkg::ADDR_CTRL) begin
            serial_port_control <= {1'b0, sfr_wdata[6:1], 1'b0};
         end
         if (sfr_addr == smp_pkg::ADDR_IRQEN) begin
            serial_irq_enable <= {4'h0, sfr_wdata[3:0]};
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         transmit_holding <= 8'h00;
      end else if (wr_tx) begin
         transmit_holding <= sfr_wdata;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         tx_empty_flag <= smp_pkg::RST_STATUS[smp_pkg::B_TX_EMPTY];
      end else if (st == smp_pkg::SMP_IDLE && go) begin
         tx_empty_flag <= 1'b1;
      end else if (wr_tx) begin
         tx_empty_flag <= 1'b0;
      end
   end

   // Receive buffer: two entries between the shifter and receive holding.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         buf_mem[0] <= 8'h00;
         buf_mem[1] <= 8'h00;
         buf_wptr <= 1'b0;
         buf_rptr <= 1'b0;
         buf_count <= 2'h0;
      end else begin
         if (buf_in_valid && buf_in_ready) begin
            buf_mem[buf_wptr] <= next_rxreg;
            buf_wptr <= ~buf_wptr;
         end
         if (buf_out_valid && buf_out_ready) begin
            buf_rptr <= ~buf_rptr;
         end
         buf_count <= buf_count + {1'b0, buf_in_valid && buf_in_ready}
                      - {1'b0, buf_out_valid && buf_out_ready};
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         receive_holding <= 8'h00;
         rx_full_flag <= 1'b0;
      end else if (buf_out_valid && buf_out_ready) begin
         receive_holding <= buf_mem[buf_rptr];
         rx_full_flag <= 1'b1;
      end else if (rd_rx) begin
         rx_full_flag <= 1'b0;
      end
   end

   // Event flags; a new event wins over the clearing status read.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         xfer_end_flag <= 1'b0;
         overrun_flag <= 1'b0;
      end else begin
         if (byte_done && tx_empty_flag) begin
            xfer_end_flag <= 1'b1;
         end else if (rd_stat) begin
            xfer_end_flag <= 1'b0;
         end
         if (buf_in_valid && (rx_full_flag || buf_out_valid)) begin
            overrun_flag <= 1'b1;
         end else if (rd_stat) begin
            overrun_flag <= 1'b0;
         end
      end
   end

   logic [7:0] status_val;
   assign status_val = {3'b000, busy, xfer_end_flag, overrun_flag,
                        tx_empty_flag, rx_full_flag};

   // Read data is registered one cycle after the read strobe.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         unique case (sfr_addr)
            smp_pkg::ADDR_CLKDIV: sfr_rdata <= serial_clock_divider;
            smp_pkg::ADDR_STATUS: sfr_rdata <= status_val;
            smp_pkg::ADDR_RXHOLD: sfr_rdata <= receive_holding;
            smp_pkg::ADDR_CTRL: sfr_rdata <= serial_port_control;
            smp_pkg::ADDR_IRQEN: sfr_rdata <= serial_irq_enable;
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(serial_irq_enable[3:0] & status_val[3:0]);
      end
   end

   // Half-period counter, running only while a byte is in progress.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt <= 8'h00;
      end else if (!busy || tick || !run_ok) begin
         cnt <= 8'h00;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end

   // Byte engine: select lead, sixteen clock edges, select trail.
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st <= smp_pkg::SMP_IDLE;
         edge_cnt <= 4'h0;
         shreg <= 8'h00;
         serial_clock_out <= 1'b0;
         serial_data_out <= 1'b0;
         slave_select_out <= 1'b1;
      end else if (!run_ok) begin
         st <= smp_pkg::SMP_IDLE;
         edge_cnt <= 4'h0;
         serial_clock_out <= clock_idle_high;
         slave_select_out <= 1'b1;
      end else begin
         unique case (st)
            smp_pkg::SMP_IDLE: begin
               serial_clock_out <= clock_idle_high;
               edge_cnt <= 4'h0;
               if (go) begin
                  st <= smp_pkg::SMP_LEAD;
                  shreg <= transmit_holding;
                  slave_select_out <= !auto_sel;
               end
            end
            smp_pkg::SMP_LEAD: begin
               if (tick) begin
                  st <= smp_pkg::SMP_SHIFT;
                  serial_clock_out <= !serial_clock_out;
                  serial_data_out <= fn_outbit(shreg, lsb_first_sel);
                  edge_cnt <= 4'h1;
               end
            end
            smp_pkg::SMP_SHIFT: begin
               if (tick) begin
                  serial_clock_out <= !serial_clock_out;
                  edge_cnt <= edge_cnt + 4'h1;
                  if (edge_cnt[0]) begin
                     shreg <= next_shreg;
                     if (edge_cnt == smp_pkg::LAST_EDGE) begin
                        st <= smp_pkg::SMP_TRAIL;
                     end
                  end else begin
                     serial_data_out <= fn_outbit(shreg, lsb_first_sel);
                  end
               end
            end
            smp_pkg::SMP_TRAIL: begin
               if (tick) begin
                  st <= smp_pkg::SMP_IDLE;
                  slave_select_out <= 1'b1;
               end
            end
         endcase
      end
   end

   // Checks on the engine and the flags.
   sequence s_load;
      st == smp_pkg::SMP_IDLE && go;
   endsequence

   sequence s_edge;
      st == smp_pkg::SMP_SHIFT && tick && run_ok;
   endsequence

   idle_clock_a: assert property (@(posedge clock) disable iff (!resetn)
      (st == smp_pkg::SMP_IDLE && $past(st) == smp_pkg::SMP_IDLE
       && $stable(clock_idle_high)) |-> serial_clock_out == clock_idle_high)
      else $error("Serial clock not at idle level.");

   select_idle_a: assert property (@(posedge clock) disable iff (!resetn)
      (st == smp_pkg::SMP_IDLE && $past(st) == smp_pkg::SMP_IDLE) |-> slave_select_out)
      else $error("Select low while idle.");

   select_fall_a: assert property (@(posedge clock) disable iff (!resetn)
      $fell(slave_select_out) |-> $past(auto_sel) && st == smp_pkg::SMP_LEAD)
      else $error("Select fell without auto select.");

   tx_empty_set_a: assert property (@(posedge clock) disable iff (!resetn)
      s_load |=> tx_empty_flag && st == smp_pkg::SMP_LEAD)
      else $error("Transmit empty not set after load.");

   tx_empty_clr_a: assert property (@(posedge clock) disable iff (!resetn)
      (wr_tx && !(st == smp_pkg::SMP_IDLE && go)) |=> !tx_empty_flag)
      else $error("Transmit empty not cleared by write.");

   xfer_end_clr_a: assert property (@(posedge clock) disable iff (!resetn)
      (rd_stat && !byte_done) |=> !xfer_end_flag)
      else $error("Transfer end not cleared by status read.");

   overrun_clr_a: assert property (@(posedge clock) disable iff (!resetn)
      (rd_stat && !buf_in_valid) |=> !overrun_flag)
      else $error("Overrun not cleared by status read.");

   half_period_a: assert property (@(posedge clock) disable iff (!resetn)
      s_edge |-> $past(cnt) == fn_half(serial_clock_divider) - 8'h02)
      else $error("Clock edge at wrong divider count.");

   last_edge_a: assert property (@(posedge clock) disable iff (!resetn)
      (s_edge ##0 (edge_cnt == smp_pkg::LAST_EDGE)) |=> st == smp_pkg::SMP_TRAIL)
      else $error("Byte did not end after sixteen edges.");

   busy_rise_a: assert property (@(posedge clock) disable iff (!resetn)
      $rose(busy) |-> $past(go))
      else $error("Busy rose without a start.");

   rx_full_clr_a: assert property (@(posedge clock) disable iff (!resetn)
      (rd_rx && !buf_out_valid) |=> !rx_full_flag)
      else $error("Receive full not cleared by read.");

endmodule : smp_master

// ---- smp_pkg.sv ----
// Constants, register map and state codes shared by the serial master port.
package smp_pkg;
   // Register addresses on the special function register port.
   localparam logic [7:0] ADDR_CLKDIV = 8'hd2;
   localparam logic [7:0] ADDR_STATUS = 8'hd3;
   localparam logic [7:0] ADDR_TXHOLD = 8'hd4;
   localparam logic [7:0] ADDR_RXHOLD = 8'hd5;
   localparam logic [7:0] ADDR_CTRL = 8'hd6;
   localparam logic [7:0] ADDR_IRQEN = 8'hd7;
   // Reset values.
   localparam logic [7:0] RST_CLKDIV = 8'h04;
   localparam logic [7:0] RST_STATUS = 8'h02;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_IRQEN = 8'h00;
   // Control register bit positions.
   localparam int B_TX_ENABLE = 6;
   localparam int B_RX_ENABLE = 5;
   localparam int B_PORT_ENABLE = 4;
   localparam int B_AUTO_SEL = 3;
   localparam int B_LSB_FIRST = 2;
   localparam int B_IDLE_HIGH = 1;
   // Status and interrupt enable bit positions.
   localparam int B_BUSY = 4;
   localparam int B_XFER_END = 3;
   localparam int B_OVERRUN = 2;
   localparam int B_TX_EMPTY = 1;
   localparam int B_RX_FULL = 0;
   // Divider select field, last clock edge of a byte and receive buffer depth.
   localparam int DIV_LSB = 2;
   localparam logic [3:0] LAST_EDGE = 4'hf;
   localparam logic [1:0] BUF_DEPTH = 2'h2;
   // Engine states.
   typedef enum logic [1:0] {
      SMP_IDLE = 2'b00,
      SMP_LEAD = 2'b01,
      SMP_SHIFT = 2'b10,
      SMP_TRAIL = 2'b11
   } smp_state_t;
endpackage : smp_pkg

// ---- smp_slave_model.sv ----
// Behavioural serial slave that answers each frame with the byte it last received.
`timescale 1ns/10ps
module smp_slave_model #(
   parameter logic [7:0] FIRST_REPLY = 8'h5a
) (
   input wire logic serial_clock_out,
   input wire logic serial_data_out,
   input wire logic slave_select_out,
   input wire logic idle_high,
   input wire logic lsb_first,
   input wire logic use_select,
   output logic serial_data_in,
   output logic [7:0] last_rx,
   output int frames
);
   logic [7:0] tx_sh = FIRST_REPLY;
   logic [7:0] rx_sh = 8'h00;
   int bits = 0;
   wire selected = !slave_select_out || !use_select;

   // Start quiet with nothing received.
   initial begin
      serial_data_in = 1'b0;
      last_rx = 8'h00;
      frames = 0;
   end

   // release when deselected.
   // A released line shows the inverse level, since nothing pulls it.
   always @(posedge slave_select_out) begin
      #1 bits = 0;
      serial_data_in = ~serial_data_in;
   end

   // drive, sample, exchange.
   // The leading edge launches a bit and the trailing edge samples the master.
   always @(serial_clock_out) begin
      if (selected && serial_clock_out !== idle_high) begin
         serial_data_in <= #1 lsb_first ? tx_sh[bits[2:0]] : tx_sh[3'd7 - bits[2:0]];
      end else if (selected) begin
         rx_sh[lsb_first ? bits[2:0] : 3'd7 - bits[2:0]] = serial_data_out;
         bits++;
         if (bits == 8) begin
            bits = 0;
            last_rx = rx_sh;
            tx_sh = rx_sh;
            frames++;
            serial_data_in <= #2 ~serial_data_in;
         end
      end
   end
endmodule : smp_slave_model

// ---- testbench.sv ----
// Self-checking bench for the serial master port with an echoing slave model.
`timescale 1ns/10ps
module testbench;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] sfr_addr = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_rdata;
   logic irq, serial_clock_out, serial_data_out, slave_select_out, serial_data_in;
   logic idle_now = 1'b0, lsb_now = 1'b0, use_sel = 1'b1, aborting = 1'b1;
   logic rd_d1 = 1'b0, rd_d2 = 1'b0, sel_low_seen = 1'b0;
   logic [7:0] last_rx, data, half_exp = 8'h02, prev = 8'h5a;
   logic [7:0] exp_q[$];
   logic [7:0] divs[4] = '{8'h04, 8'h24, 8'hfc, 8'h0c};
   logic [7:0] ra[6] = '{8'hd2, 8'hd3, 8'hd6, 8'hd7, 8'hd5, 8'hd8};
   logic [7:0] rv[6] = '{8'h04, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] fv[6] = '{8'hfc, 8'h02, 8'h7e, 8'h0f, 8'h00, 8'h00};
   int frames, f0, edges = 0, miscompares = 0, cmp_count = 0;
   time t_edge = 0;

   // Peripheral clock at 40 MHz.
   always #12.5 clock = ~clock;

   smp_master i_dut (.clock(clock), .resetn(resetn), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .irq(irq), .serial_clock_out(serial_clock_out), .serial_data_out(serial_data_out),
      .slave_select_out(slave_select_out), .serial_data_in(serial_data_in));

   smp_slave_model i_slave (.serial_clock_out(serial_clock_out),
      .serial_data_out(serial_data_out), .slave_select_out(slave_select_out),
      .idle_high(idle_now), .lsb_first(lsb_now), .use_select(use_sel),
      .serial_data_in(serial_data_in), .last_rx(last_rx), .frames(frames));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test

   task automatic tick(input int n = 1);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      tick();
      sfr_wr = 1'b0;
      tick();
   endtask : wr

   // A read notes its expected value; the monitor compares it when it lands.
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sfr_addr = a;
      sfr_rd = 1'b1;
      exp_q.push_back(e);
      tick();
      sfr_rd = 1'b0;
      tick(2);
   endtask : rd

   task automatic wait_frames(input int target);
      repeat (4000) if (frames < target) tick();
      check(8'(frames - target), 8'h00);
   endtask : wait_frames

   task automatic wait_irq();
      repeat (3000) if (irq !== 1'b1) tick();
      check({7'h0, irq}, 8'h01);
   endtask : wait_irq

   // Read data monitor takes the oldest note at the falling edge two cycles after the strobe.
   always @(posedge clock) begin
      rd_d1 <= sfr_rd;
      rd_d2 <= rd_d1;
   end
   always @(negedge clock) begin
      if (rd_d2) check(sfr_rdata, exp_q.pop_front());
   end

   // Serial clock monitor counts edges and spacing while the slave is selected.
   always @(serial_clock_out) begin
      if (resetn && !slave_select_out) begin
         edges++;
         if (edges == 2 && !aborting) check(8'(($time - t_edge) / 25), half_exp);
         t_edge = $time;
      end
   end
   always @(posedge slave_select_out) begin
      if (resetn && !aborting) begin
         check(8'(edges), 8'h10);
         check({7'h0, serial_clock_out}, {7'h0, idle_now});
      end
      edges = 0;
   end
   always @(negedge slave_select_out) sel_low_seen = 1'b1;

   // Watchdog cuts a hang short.
   initial begin
      #2000000;
      miscompares++;
      stop_test();
   end

   // Main sequence.
   initial begin
      void'($urandom(76573));
      divs[3] = 8'(4 * $urandom_range(2, 8));
      repeat (20) @(posedge clock);
      #1 resetn = 1'b1;
      aborting = 1'b0;
      tick();
      for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
      for (int i = 0; i < 6; i++) wr(ra[i], 8'hff);
      for (int i = 0; i < 6; i++) rd(ra[i], fv[i]);
      check({7'h0, irq}, 8'h01);
      rd(smp_pkg::ADDR_TXHOLD, 8'h00);
      $display("test registers finished");
      for (int i = 0; i < 4; i++) begin
         idle_now = i[0];
         lsb_now = i[1];
         half_exp = divs[i] >> 1;
         data = 8'($urandom);
         wr(smp_pkg::ADDR_CLKDIV, divs[i]);
         wr(smp_pkg::ADDR_IRQEN, 8'h01);
         wr(smp_pkg::ADDR_CTRL, {4'h7, 1'b1, lsb_now, idle_now, 1'b0});
         wr(smp_pkg::ADDR_TXHOLD, data);
         wait_irq();
         tick(int'(half_exp)); // Let the select trail end before busy is read.
         rd(smp_pkg::ADDR_STATUS, 8'h0b);
         rd(smp_pkg::ADDR_STATUS, 8'h03);
         rd(smp_pkg::ADDR_RXHOLD, prev);
         tick();
         check({7'h0, irq}, 8'h00);
         rd(smp_pkg::ADDR_STATUS, 8'h02);
         check(last_rx, data);
         prev = data;
      end
      $display("test modes finished");
      idle_now = 1'b0;
      lsb_now = 1'b0;
      half_exp = 8'h02;
      wr(smp_pkg::ADDR_CLKDIV, 8'h04);
      wr(smp_pkg::ADDR_IRQEN, 8'h04);
      wr(smp_pkg::ADDR_CTRL, 8'h78);
      f0 = frames;
      data = 8'($urandom);
      wr(smp_pkg::ADDR_TXHOLD, data);
      tick(8);
      rd(smp_pkg::ADDR_STATUS, 8'h12);
      wr(smp_pkg::ADDR_TXHOLD, ~data);
      tick(2);
      rd(smp_pkg::ADDR_STATUS, 8'h10);
      wait_frames(f0 + 2);
      tick(6);
      check({7'h0, irq}, 8'h01);
      rd(smp_pkg::ADDR_STATUS, 8'h0f);
      tick();
      check({7'h0, irq}, 8'h00);
      rd(smp_pkg::ADDR_RXHOLD, prev);
      rd(smp_pkg::ADDR_RXHOLD, data);
      prev = ~data;
      $display("test back to back finished");
      wr(smp_pkg::ADDR_IRQEN, 8'h00);
      f0 = frames;
      aborting = 1'b1;
      wr(smp_pkg::ADDR_TXHOLD, 8'h3c);
      tick(10);
      wr(smp_pkg::ADDR_CTRL, 8'h38);
      tick(2);
      check({6'h0, serial_clock_out, slave_select_out}, 8'h01);
      tick(60);
      check(8'(frames - f0), 8'h00);
      rd(smp_pkg::ADDR_STATUS, 8'h02);
      aborting = 1'b0;
      $display("test abort finished");
      wr(smp_pkg::ADDR_CTRL, 8'h60);
      wr(smp_pkg::ADDR_TXHOLD, 8'ha5);
      tick(80);
      check(8'(frames - f0), 8'h00);
      rd(smp_pkg::ADDR_STATUS, 8'h00);
      use_sel = 1'b0;
      sel_low_seen = 1'b0;
      wr(smp_pkg::ADDR_IRQEN, 8'h08);
      wr(smp_pkg::ADDR_CTRL, 8'h50);
      wait_frames(f0 + 1);
      tick(6);
      check({7'h0, sel_low_seen}, 8'h00);
      check({7'h0, irq}, 8'h01);
      rd(smp_pkg::ADDR_STATUS, 8'h0a);
      check(last_rx, 8'ha5);
      $display("test enables finished");
      resetn = 1'b0;
      tick(2);
      resetn = 1'b1;
      tick();
      rd(smp_pkg::ADDR_CTRL, 8'h00);
      rd(smp_pkg::ADDR_STATUS, 8'h02);
      $display("test reset finished");
      stop_test();
   end
endmodule : testbench
